// ---- pkg/fbwp_params.svh ----
// constants of the flash block write-protect logic
`ifndef FBWP_PARAMS_SVH
`define FBWP_PARAMS_SVH
`define FBWP_OP_WRITE_ENABLE_CMD 8'h06
`define FBWP_OP_WRITE_DISABLE 8'h04
`define FBWP_OP_WRITE_STATUS_CMD 8'h01
`define FBWP_OP_WRITE_FUNCTION 8'h42
`define FBWP_OP_SET_READ_PARAMS_VOLATILE 8'hc0
`define FBWP_OP_BANK_ADDR_VOLATILE_WRITE 8'h17
`define FBWP_OP_CHIP_ERASE_CMD_A 8'hc7
`define FBWP_OP_CHIP_ERASE_CMD_B 8'h60
`define FBWP_LEN_SHORT 6'h08
`define FBWP_LEN_DATA 6'h10
`define FBWP_LEN_ADDR 6'h28
`define FBWP_ST_FIELD_LSB 2
`define FBWP_ST_FIELD_MSB 5
`define FBWP_ST_QUAD_BIT 6
`define FBWP_ST_DISABLE_BIT 7
`define FBWP_ST_LATCH_BIT 1
`define FBWP_FN_SELECT_BIT 1
`define FBWP_STATUS_RESET 6'h00
`define FBWP_SELECT_RESET 1'b0
`define FBWP_BLOCKS_64K 12'h800
`define FBWP_BLOCKS_256K 12'h200
`define FBWP_PROT_1536 12'h600
`define FBWP_PROT_1792 12'h700
`define FBWP_PROT_1920 12'h780
`define FBWP_BLK_MSB 26
`define FBWP_BLK64_LSB 16
`define FBWP_BLK256_LSB 18
`define FBWP_REG_STATUS 8'h00
`define FBWP_REG_FUNCTION 8'h04
`define FBWP_REG_CHECK_ADDR 8'h08
`define FBWP_REG_CHECK_RESULT 8'h0c
`define FBWP_REG_VOLATILE 8'h10
`define FBWP_REG_REFUSE_COUNT 8'h14
`endif

// ---- pkg/fbwp_pkg.sv ----
// types and opcode helpers of the flash block write-protect logic
`include "fbwp_params.svh"
package fbwp_pkg;
    typedef enum logic [1:0] {CLS_SHORT, CLS_DATA, CLS_ADDR} fbwp_cls_t;
    typedef enum logic [1:0] {OP_PROGRAM, OP_ERASE, OP_CHIP} fbwp_op_t;

    function automatic logic fbwp_is_program(input logic [7:0] op);
        return op == 8'h02 || op == 8'h12 || op == 8'h32 || op == 8'h38 || op == 8'h34 || op == 8'h3e;
    endfunction : fbwp_is_program

    function automatic logic fbwp_is_erase(input logic [7:0] op);
        return op == 8'h20 || op == 8'hd7 || op == 8'h21 || op == 8'h52 || op == 8'h5c
            || op == 8'hd8 || op == 8'hdc;
    endfunction : fbwp_is_erase

    // frame length class; unknown opcodes end after the opcode byte
    function automatic fbwp_cls_t fbwp_cmd_class(input logic [7:0] op);
        if (fbwp_is_program(op) || fbwp_is_erase(op)) begin
            return CLS_ADDR;
        end
        if (op == `FBWP_OP_WRITE_STATUS_CMD || op == `FBWP_OP_WRITE_FUNCTION
            || op == `FBWP_OP_SET_READ_PARAMS_VOLATILE || op == `FBWP_OP_BANK_ADDR_VOLATILE_WRITE) begin
            return CLS_DATA;
        end
        return CLS_SHORT;
    endfunction : fbwp_cmd_class

    function automatic logic [5:0] fbwp_cls_len(input fbwp_cls_t c);
        return (c == CLS_ADDR) ? `FBWP_LEN_ADDR : (c == CLS_DATA) ? `FBWP_LEN_DATA : `FBWP_LEN_SHORT;
    endfunction : fbwp_cls_len
endpackage : fbwp_pkg

// ---- pkg/fbwp_link_if.sv ----
// carrier between the link shifter and the system-side core
`timescale 1ns/10ps
interface fbwp_link_if;
    logic tog;
    logic [7:0] opcode;
    logic [31:0] addr;
    logic [7:0] data;
    logic qe;
    modport link (output tog, output opcode, output addr, output data, input qe);
    modport core (input tog, input opcode, input addr, input data, output qe);
endinterface : fbwp_link_if

// ---- verilog/fbwp_range.sv ----
// decodes the protect field into a block range and tests one address against it
`timescale 1ns/10ps
`include "fbwp_params.svh"
module fbwp_range
    import fbwp_pkg::*;
#(
    parameter bit BIG_BLOCK = 1'b0
) (
    input wire logic [3:0] field,
    input wire logic top_bottom_select,
    input wire logic [31:0] addr,
    output logic hit
);
    logic [11:0] total;
    logic [11:0] blk;
    logic [11:0] pow;
    logic [11:0] count64;
    logic [11:0] count256;
    logic [11:0] count;

    // block index of the target
    assign total = BIG_BLOCK ? `FBWP_BLOCKS_256K : `FBWP_BLOCKS_64K;
    assign blk = BIG_BLOCK ? {3'h0, addr[`FBWP_BLK_MSB:`FBWP_BLK256_LSB]}
                           : {1'h0, addr[`FBWP_BLK_MSB:`FBWP_BLK64_LSB]};
    // doubling steps; field zero is masked below so the wrapped shift is harmless
    assign pow = 12'h001 << (field - 4'h1);
    assign count64 = (field == 4'h0) ? 12'h000 :
                     (field <= 4'hb) ? pow :
                     (field == 4'hc) ? `FBWP_PROT_1536 :
                     (field == 4'hd) ? `FBWP_PROT_1792 :
                     (field == 4'he) ? `FBWP_PROT_1920 : `FBWP_BLOCKS_64K;
    // 101x and 11xx fall through to the whole array
    assign count256 = (field == 4'h0) ? 12'h000 : (field <= 4'h9) ? pow : `FBWP_BLOCKS_256K;
    assign count = BIG_BLOCK ? count256 : count64;
    // bottom run starts at block zero, top run ends at the last block
    assign hit = top_bottom_select ? (blk < count) : (blk >= total - count);
endmodule : fbwp_range

// ---- verilog/fbwp_link.sv ----
// serial command shifter running on the link clock
`timescale 1ns/10ps
`include "fbwp_params.svh"
module fbwp_link
    import fbwp_pkg::*;
(
    input wire logic sck,
    input wire logic cs_n,
    input wire logic rst,
    input wire logic io0_in,
    input wire logic io1_in,
    input wire logic io2_in,
    input wire logic io3_in,
    fbwp_link_if.link lnk
);
    logic [1:0] qe_sync_reg;
    logic [5:0] cnt_reg;
    logic [5:0] cnt_next;
    logic [47:0] sh_reg;
    logic [47:0] sh_next;
    logic [7:0] op_reg;
    logic done_reg;
    logic tog_reg;
    logic [47:0] word_reg;
    logic [47:0] word_new;
    logic [7:0] op_now;
    logic [5:0] need;
    logic quad_now;
    logic hold_now;
    logic shift_en;
    logic finish;

    // opcode always arrives on one line; later phases widen to four when quad is on
    assign quad_now = qe_sync_reg[1] && (cnt_reg >= `FBWP_LEN_SHORT);
    // the fourth pin pauses shifting only while it still has its hold role
    assign hold_now = !qe_sync_reg[1] && !io3_in;
    assign shift_en = !done_reg && !hold_now;
    assign cnt_next = cnt_reg + (quad_now ? 6'h04 : 6'h01);
    assign sh_next = quad_now ? {sh_reg[43:0], io3_in, io2_in, io1_in, io0_in} : {sh_reg[46:0], io0_in};
    assign op_now = (cnt_reg < `FBWP_LEN_SHORT) ? sh_next[7:0] : op_reg;
    assign need = fbwp_cls_len(fbwp_cmd_class(op_now));
    assign finish = shift_en && (cnt_next == need);
    // align opcode, address and data into one word
    assign word_new = (need == `FBWP_LEN_ADDR) ? {sh_next[39:0], 8'h00} :
                      (need == `FBWP_LEN_DATA) ? {sh_next[15:8], 32'h0000_0000, sh_next[7:0]} :
                      {sh_next[7:0], 40'h00_0000_0000};

    // frame state, cleared by the frame's own select so a stopped clock leaves nothing hanging
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            qe_sync_reg <= 2'h0;
            cnt_reg <= 6'h00;
            sh_reg <= 48'h0;
            op_reg <= 8'h00;
            done_reg <= 1'b0;
        end else begin
            qe_sync_reg <= {qe_sync_reg[0], lnk.qe};
            if (shift_en) begin
                cnt_reg <= cnt_next;
                sh_reg <= sh_next;
                op_reg <= op_now;
                done_reg <= finish;
            end
        end
    end

    // finished word is held until the next frame ends; the toggle tells the core
    always_ff @(posedge sck or posedge rst) begin
        if (rst) begin
            tog_reg <= 1'b0;
            word_reg <= 48'h0;
        end else if (finish && !cs_n) begin
            tog_reg <= ~tog_reg;
            word_reg <= word_new;
        end
    end

    assign lnk.tog = tog_reg;
    assign lnk.opcode = word_reg[47:40];
    assign lnk.addr = word_reg[39:8];
    assign lnk.data = word_reg[7:0];
endmodule : fbwp_link

// ---- verilog/fbwp_top.sv ----
// flash block write-protect core with wishbone register access
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
`include "fbwp_params.svh"
module fbwp_top
    import fbwp_pkg::*;
#(
    parameter bit BIG_BLOCK = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic io0_in,
    input wire logic io1_in,
    input wire logic io2_in,
    output logic io2_out,
    output logic io2_oe_n,
    input wire logic io3_in,
    output logic io3_out,
    output logic io3_oe_n,
    output logic op_valid,
    output logic op_refused,
    output fbwp_op_t op_kind,
    output logic [31:0] op_addr
);
    fbwp_link_if lnk ();

    logic [5:0] stat_reg;
    logic [5:0] stat_next;
    logic wel_reg;
    logic wel_next;
    logic tbs_reg;
    logic tbs_next;
    logic [7:0] rdparam_reg;
    logic [7:0] bank_reg;
    logic [31:0] check_addr_reg;
    logic [15:0] refuse_cnt_reg;
    logic [15:0] refuse_cnt_next;
    logic [1:0] wp_sync_reg;
    logic [1:0] tog_sync_reg;
    logic tog_seen_reg;
    logic op_valid_reg;
    logic op_refused_reg;
    fbwp_op_t op_kind_reg;
    logic [31:0] op_addr_reg;
    logic ack_reg;
    logic [31:0] dat_reg;
    logic pin_out_reg;
    logic pin_oe_n_reg;

    logic cmd_fire;
    logic [7:0] op;
    logic [3:0] field;
    logic quad_on;
    logic wp_low;
    logic status_lock;
    logic is_write_status_cmd;
    logic is_pe;
    logic is_chip;
    logic hit;
    logic check_hit;
    logic write_status_cmd_ok;
    logic wrfr_ok;
    logic pe_ok;
    logic pe_refused;
    logic chip_ok;
    logic chip_refused;
    logic any_refused;
    logic wb_req;
    logic wb_wr;
    logic [31:0] rd_word;

    fbwp_link u_link (
        .sck(sck),
        .cs_n(cs_n),
        .rst(rst),
        .io0_in(io0_in),
        .io1_in(io1_in),
        .io2_in(io2_in),
        .io3_in(io3_in),
        .lnk(lnk.link)
    );

    // target of the incoming command
    fbwp_range #(.BIG_BLOCK(BIG_BLOCK)) u_cmd_range (
        .field(field),
        .top_bottom_select(tbs_reg),
        .addr(lnk.addr),
        .hit(hit)
    );

    // software probe of the same decode
    fbwp_range #(.BIG_BLOCK(BIG_BLOCK)) u_check_range (
        .field(field),
        .top_bottom_select(tbs_reg),
        .addr(check_addr_reg),
        .hit(check_hit)
    );

    // status layout: disable, quad, four field bits
    assign field = stat_reg[3:0];
    assign quad_on = stat_reg[4];
    assign lnk.qe = quad_on;
    // the protect pin only counts while quad mode leaves it a protect pin
    assign wp_low = !quad_on && !wp_sync_reg[1];
    assign status_lock = stat_reg[5] && wp_low;

    // command decode; the word is stable for a whole frame after its toggle
    assign cmd_fire = ce && (tog_sync_reg[1] ^ tog_seen_reg);
    assign op = lnk.opcode;
    assign is_write_status_cmd = op == `FBWP_OP_WRITE_STATUS_CMD;
    assign is_pe = fbwp_is_program(op) || fbwp_is_erase(op);
    assign is_chip = op == `FBWP_OP_CHIP_ERASE_CMD_A || op == `FBWP_OP_CHIP_ERASE_CMD_B;
    assign write_status_cmd_ok = cmd_fire && is_write_status_cmd && wel_reg && !status_lock;
    assign wrfr_ok = cmd_fire && op == `FBWP_OP_WRITE_FUNCTION && wel_reg;
    assign pe_ok = cmd_fire && is_pe && wel_reg && !hit;
    assign pe_refused = cmd_fire && is_pe && wel_reg && hit;
    assign chip_ok = cmd_fire && is_chip && wel_reg && field == 4'h0;
    assign chip_refused = cmd_fire && is_chip && wel_reg && field != 4'h0;
    assign any_refused = pe_refused || chip_refused;

    // next values of the protection state
    assign stat_next = write_status_cmd_ok ? lnk.data[`FBWP_ST_DISABLE_BIT:`FBWP_ST_FIELD_LSB] : stat_reg;
    // select bit can only be set, never cleared
    assign tbs_next = tbs_reg | (wrfr_ok && lnk.data[`FBWP_FN_SELECT_BIT]);
    // a locked status write leaves the latch alone, as if never sent
    assign wel_next = !cmd_fire ? wel_reg :
                      (op == `FBWP_OP_WRITE_ENABLE_CMD) ? 1'b1 :
                      (op == `FBWP_OP_WRITE_DISABLE) ? 1'b0 :
                      (write_status_cmd_ok || wrfr_ok || (wel_reg && (is_pe || is_chip))) ? 1'b0 : wel_reg;
    // a refusal in the same cycle as a clear still counts
    assign refuse_cnt_next = (wb_wr && wb_adr_i == `FBWP_REG_REFUSE_COUNT) ? {15'h0000, any_refused}
                             : refuse_cnt_reg + {15'h0000, any_refused};

    // wishbone decode; unmapped reads return zero and are still acked
    assign wb_req = ce && wb_cyc_i && wb_stb_i && !ack_reg;
    assign wb_wr = wb_req && wb_we_i;
    assign rd_word = (wb_adr_i == `FBWP_REG_STATUS) ? {24'h000000, stat_reg, wel_reg, 1'b0} :
                     (wb_adr_i == `FBWP_REG_FUNCTION) ? {30'h00000000, tbs_reg, 1'b0} :
                     (wb_adr_i == `FBWP_REG_CHECK_ADDR) ? check_addr_reg :
                     (wb_adr_i == `FBWP_REG_CHECK_RESULT) ? {30'h00000000, field == 4'h0, check_hit} :
                     (wb_adr_i == `FBWP_REG_VOLATILE) ? {16'h0000, bank_reg, rdparam_reg} :
                     (wb_adr_i == `FBWP_REG_REFUSE_COUNT) ? {16'h0000, refuse_cnt_reg} : 32'h0000_0000;

    // pin and toggle synchronisers; first stages feed only the second
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wp_sync_reg <= 2'h3;
            tog_sync_reg <= 2'h0;
            tog_seen_reg <= 1'b0;
        end else if (ce) begin
            wp_sync_reg <= {wp_sync_reg[0], io2_in};
            tog_sync_reg <= {tog_sync_reg[0], lnk.tog};
            tog_seen_reg <= tog_sync_reg[1];
        end
    end

    // protection state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stat_reg <= `FBWP_STATUS_RESET;
            wel_reg <= 1'b0;
            tbs_reg <= `FBWP_SELECT_RESET;
        end else if (ce) begin
            stat_reg <= stat_next;
            wel_reg <= wel_next;
            tbs_reg <= tbs_next;
        end
    end

    // volatile writes that skip the write-enable step
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdparam_reg <= 8'h00;
            bank_reg <= 8'h00;
        end else if (cmd_fire) begin
            if (op == `FBWP_OP_SET_READ_PARAMS_VOLATILE) begin
                rdparam_reg <= lnk.data;
            end
            if (op == `FBWP_OP_BANK_ADDR_VOLATILE_WRITE) begin
                bank_reg <= lnk.data;
            end
        end
    end

    // outcome toward the array: a refused operation never reaches it
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            op_valid_reg <= 1'b0;
            op_refused_reg <= 1'b0;
            op_kind_reg <= OP_PROGRAM;
            op_addr_reg <= 32'h0000_0000;
            refuse_cnt_reg <= 16'h0000;
        end else if (ce) begin
            op_valid_reg <= pe_ok || chip_ok;
            op_refused_reg <= any_refused;
            refuse_cnt_reg <= refuse_cnt_next;
            if (pe_ok || chip_ok) begin
                op_kind_reg <= chip_ok ? OP_CHIP : fbwp_is_program(op) ? OP_PROGRAM : OP_ERASE;
                op_addr_reg <= lnk.addr;
            end
        end
    end

    // probe address, byte lanes honoured
    for (genvar b = 0; b < 4; b++) begin : g_lane
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                check_addr_reg[8*b +: 8] <= 8'h00;
            end else if (wb_wr && wb_sel_i[b] && wb_adr_i == `FBWP_REG_CHECK_ADDR) begin
                check_addr_reg[8*b +: 8] <= wb_dat_i[8*b +: 8];
            end
        end
    end

    // single-cycle ack one edge after the request
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else if (ce) begin
            ack_reg <= wb_req;
            dat_reg <= wb_req ? rd_word : 32'h0000_0000;
        end
    end

    // reads of the array are outside this block, so the quad lines are never driven
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_out_reg <= 1'b0;
            pin_oe_n_reg <= 1'b1;
        end else if (ce) begin
            pin_out_reg <= 1'b0;
            pin_oe_n_reg <= 1'b1;
        end
    end

    assign wb_dat_o = dat_reg;
    assign wb_ack_o = ack_reg;
    assign io2_out = pin_out_reg;
    assign io2_oe_n = pin_oe_n_reg;
    assign io3_out = pin_out_reg;
    assign io3_oe_n = pin_oe_n_reg;
    assign op_valid = op_valid_reg;
    assign op_refused = op_refused_reg;
    assign op_kind = op_kind_reg;
    assign op_addr = op_addr_reg;

    // checks on the protection decisions and on the bus ack
    default clocking dc @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_write_status_cmd_open;
        cmd_fire && is_write_status_cmd && wel_reg && !wp_low;
    endsequence

    sequence s_write_status_cmd_free;
        cmd_fire && is_write_status_cmd && wel_reg && !stat_reg[5];
    endsequence

    a_refuse_protected: assert property (cmd_fire && is_pe && wel_reg && hit |=> op_refused && !op_valid)
        else $error("protected target was not refused");
    a_chip_erase_gate: assert property (op_valid && op_kind == OP_CHIP |-> $past(field) == 4'h0)
        else $error("chip erase passed with protect field set");
    a_status_locked: assert property (cmd_fire && is_write_status_cmd && status_lock |=> $stable(stat_reg) && $stable(wel_reg))
        else $error("locked status changed");
    a_status_open: assert property (s_write_status_cmd_open |=> stat_reg == $past(lnk.data[7:2]))
        else $error("status write with pin high not applied");
    a_status_free: assert property (s_write_status_cmd_free |=> stat_reg == $past(lnk.data[7:2]) ##1 !wel_reg)
        else $error("status write with disable clear not applied");
    a_volatile_no_latch: assert property (cmd_fire && op == `FBWP_OP_SET_READ_PARAMS_VOLATILE && !wel_reg
        |=> rdparam_reg == $past(lnk.data))
        else $error("volatile parameter write needed the latch");
    a_write_status_cmd_needs_latch: assert property (cmd_fire && is_write_status_cmd && !wel_reg |=> $stable(stat_reg))
        else $error("status write without latch took effect");
    a_select_sticky: assert property (tbs_reg |=> tbs_reg)
        else $error("select bit returned to zero");
    a_range_none: assert property (field == 4'h0 |-> !hit && !check_hit)
        else $error("empty field protected a block");
    a_ack_pulse: assert property (wb_ack_o && ce |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
endmodule : fbwp_top

// ---- sim/fbwp_host.sv ----
// serial host model that drives frames into the flash link
`timescale 1ns/10ps
module fbwp_host (
    output logic sck,
    output logic cs_n,
    output logic io0,
    output logic io1,
    output logic io2,
    output logic io3
);
    logic wp_n = 1'b1;
    // protect pin level is set by the bench; hold stays inactive
    assign io2 = wp_n;
    assign io3 = 1'b1;
    assign io1 = ~io0;
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        io0 = 1'b0;
    end
    // msb first, mode 0; the clock stands still between frames
    task automatic frame(input logic [39:0] bits, input int n);
        cs_n = 1'b0;
        #16;
        for (int i = 0; i < n; i++) begin
            io0 = bits[39 - i];
            #16;
            sck = 1'b1;
            #16;
            sck = 1'b0;
        end
        #16;
        cs_n = 1'b1;
        io0 = ~io0; // released line shows no stale bit
        #160; // frame spacing well above the minimum
    endtask : frame
endmodule : fbwp_host

// ---- sim/flash_block_write_protect_tb.sv ----
// self-checking bench for the flash block write-protect core
`timescale 1ns/10ps
`include "fbwp_params.svh"
module flash_block_write_protect_tb import fbwp_pkg::*; ;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] rd_data, wb_dat_o, op_addr;
    logic wb_ack_o, sck, cs_n, io0, io1, h_io2, h_io3, io2_out, io2_oe_n, io3_out, io3_oe_n, op_valid, op_refused;
    fbwp_op_t op_kind;
    int mismatches = 0;
    int samples_checked = 0;
    int n_valid = 0;
    int n_refused = 0;
    always #4 clk_sys = ~clk_sys;
    // count array-side pulses so tests can compare before and after
    always @(posedge clk_sys) begin
        if (op_valid === 1'b1) n_valid <= n_valid + 1;
        if (op_refused === 1'b1) n_refused <= n_refused + 1;
    end
    fbwp_host fbwp_host_inst (.sck(sck), .cs_n(cs_n), .io0(io0), .io1(io1), .io2(h_io2), .io3(h_io3));
    fbwp_top fbwp_top_inst (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .sck(sck), .cs_n(cs_n), .io0_in(io0), .io1_in(io1),
        .io2_in(io2_oe_n ? h_io2 : io2_out), .io2_out(io2_out), .io2_oe_n(io2_oe_n),
        .io3_in(io3_oe_n ? h_io3 : io3_out), .io3_out(io3_out), .io3_oe_n(io3_oe_n),
        .op_valid(op_valid), .op_refused(op_refused), .op_kind(op_kind), .op_addr(op_addr));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    // classic single cycle; held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= wd;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd_data = wb_dat_o;
        chk({31'h0, wb_ack_o}, 32'h1, "bus ack");
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : wb
    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp, input string what);
        wb(1'b0, adr, 32'h0);
        chk(rd_data, exp, what);
    endtask : rdchk
    // the command lands a few cycles after its last link edge
    task automatic spi(input logic [7:0] op, input logic [31:0] arg, input int n);
        fbwp_host_inst.frame({op, arg}, n);
        repeat (8) @(posedge clk_sys);
    endtask : spi
    task automatic set_status(input logic [7:0] d);
        spi(8'h06, 32'h0, 8);
        spi(8'h01, {d, 24'h0}, 16);
    endtask : set_status
    task automatic check_blk(input int blk, input logic [31:0] exp);
        wb(1'b1, `FBWP_REG_CHECK_ADDR, (32'(blk) << 16) | 32'h1234);
        rdchk(`FBWP_REG_CHECK_RESULT, exp, "check result");
    endtask : check_blk
    task automatic run_op(input logic [7:0] op, input logic [31:0] a, input int n, input bit refused);
        int v0, r0;
        v0 = n_valid;
        r0 = n_refused;
        spi(8'h06, 32'h0, 8);
        spi(op, a, n);
        chk(32'(n_valid - v0), {31'h0, !refused}, "accepted pulses");
        chk(32'(n_refused - r0), {31'h0, refused}, "refused pulses");
    endtask : run_op
    function automatic int prot_blocks(input int f);
        if (f == 0) return 0;
        if (f <= 11) return 1 << (f - 1);
        return (f == 12) ? 1536 : (f == 13) ? 1792 : (f == 14) ? 1920 : 2048;
    endfunction : prot_blocks
    task automatic test_done;
        $display("checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    // watchdog sized well beyond the roughly 50 us of traffic
    initial begin
        #400000;
        $display("wrong value at %0t: watchdog expired", $time);
        mismatches++;
        test_done();
    end
    initial begin
        int nb;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rdchk(`FBWP_REG_STATUS, 32'h0, "status reset");
        rdchk(8'h1c, 32'h0, "unmapped");
        spi(8'h01, 32'h3c00_0000, 16);
        rdchk(`FBWP_REG_STATUS, 32'h0, "write without latch");
        spi(8'hc0, 32'h5a00_0000, 16);
        spi(8'h17, 32'h0300_0000, 16);
        rdchk(`FBWP_REG_VOLATILE, 32'h035a, "volatile regs");
        // quad lines stay released: both outputs low, both enables high
        chk({28'h0, io2_out, io2_oe_n, io3_out, io3_oe_n}, 32'h5, "quad pins released");
        $display("test basics done");
        for (int f = 0; f < 16; f++) begin
            nb = prot_blocks(f);
            set_status(8'(f << 2));
            rdchk(`FBWP_REG_STATUS, 32'(f << 2), "protect field");
            if (nb != 0) check_blk(2048 - nb, 32'h1);
            if (nb != 2048) check_blk(2047 - nb, {30'h0, f == 0, 1'b0});
        end
        $display("test field table done");
        set_status(8'h04);
        run_op(8'hd8, 32'h07ff_0000, 40, 1'b1);
        run_op(8'h20, 32'h07fe_f000, 40, 1'b0);
        chk({30'h0, op_kind}, {30'h0, OP_ERASE}, "op kind");
        chk(op_addr, 32'h07fe_f000, "op addr");
        run_op(8'hc7, 32'h0, 8, 1'b1);
        set_status(8'h00);
        run_op(8'h60, 32'h0, 8, 1'b0);
        chk({30'h0, op_kind}, {30'h0, OP_CHIP}, "chip kind");
        // one protected erase and one chip erase were refused so far
        rdchk(`FBWP_REG_REFUSE_COUNT, 32'h2, "refuse count");
        wb(1'b1, `FBWP_REG_REFUSE_COUNT, 32'h0);
        rdchk(`FBWP_REG_REFUSE_COUNT, 32'h0, "refuse count cleared");
        $display("test array ops done");
        set_status(8'h80);
        fbwp_host_inst.wp_n = 1'b0;
        set_status(8'h84);
        rdchk(`FBWP_REG_STATUS, 32'h82, "locked status");
        fbwp_host_inst.wp_n = 1'b1;
        set_status(8'h08);
        rdchk(`FBWP_REG_STATUS, 32'h08, "pin high write");
        fbwp_host_inst.wp_n = 1'b0;
        set_status(8'h0c);
        rdchk(`FBWP_REG_STATUS, 32'h0c, "no lock");
        fbwp_host_inst.wp_n = 1'b1;
        $display("test status lock done");
        set_status(8'hc0);
        rdchk(`FBWP_REG_STATUS, 32'hc0, "quad on");
        // with quad on a low third pin is data, not a lock; the data byte arrives as two nibbles
        // nibble is {io3 high, io2 low, ~bit, bit}: bits 1 then 0 give 9ah
        fbwp_host_inst.wp_n = 1'b0;
        set_status(8'h80);
        rdchk(`FBWP_REG_STATUS, 32'h98, "quad data write");
        fbwp_host_inst.wp_n = 1'b1;
        $display("test quad mode done");
        spi(8'h06, 32'h0, 8);
        spi(8'h42, 32'h0200_0000, 16);
        rdchk(`FBWP_REG_FUNCTION, 32'h2, "select set");
        set_status(8'h04);
        check_blk(0, 32'h1);
        check_blk(1, 32'h0);
        spi(8'h06, 32'h0, 8);
        spi(8'h42, 32'h0, 16);
        rdchk(`FBWP_REG_FUNCTION, 32'h2, "select sticky");
        $display("test bottom select done");
        test_done();
    end
endmodule : flash_block_write_protect_tb
